// [hdl/tlss_ms_timer.sv]
// Millisecond countdown timer for scan, channel and settling intervals
`timescale 1ns/100ps
module tlss_ms_timer
   import tlss_pkg::*;
#(
   parameter int W       = INTV_W,
   parameter int PRE_CYC = MS_CYC
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              expired
);

   logic [W-1:0]     cnt_q;
   logic [W-1:0]     cnt_d;
   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_d;
   logic             exp_q;
   logic             exp_d;

   // Prescaler restarts on load so the first millisecond is whole
   always_comb begin
      cnt_d = cnt_q;
      pre_d = pre_q;
      if (load) begin
         cnt_d = load_val;
         pre_d = '0;
      end else if (cnt_q != '0) begin
         if (pre_q == PRE_W'(PRE_CYC - 1)) begin
            pre_d = '0;
            cnt_d = cnt_q - W'(1);
         end else begin
            pre_d = pre_q + PRE_W'(1);
         end
      end
      exp_d = (cnt_d == '0);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
         pre_q <= '0;
         exp_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         pre_q <= pre_d;
         exp_q <= exp_d;
      end
   end

   assign expired = exp_q;

   a_ms_load_waits: assert property (@(posedge clk) disable iff (!rst_b)
      load && load_val != '0 |=> !expired)
      else $error("Timer expired right after a nonzero load");

endmodule

// [hdl/tlss_pkg.sv]
// Constants, register map and types of the three-layer scan sequencer
package tlss_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ      = 50_000_000;
   localparam int TIMER_RES_MS = 1;
   localparam int MS_CYC      = CLK_HZ / 1000 * TIMER_RES_MS;
   localparam int PRE_W       = 16;

   // ---------------------------------------------------------------
   // Widths and limits
   // ---------------------------------------------------------------
   localparam int              CNT_W    = 14;
   localparam logic [13:0]     CNT_MIN  = 14'h0001;
   localparam logic [13:0]     CNT_MAX  = 14'h270F;
   localparam int              INTV_W   = 27;
   localparam logic [26:0]     INTV_MIN = 27'h000_0001;
   localparam logic [26:0]     INTV_MAX = 27'h5F5_E0FF;
   localparam int              LIST_W   = 8;

   // ---------------------------------------------------------------
   // Register offsets and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_SPACING   = 8'h04;
   localparam logic [7:0] OFS_ARM_CNT   = 8'h08;
   localparam logic [7:0] OFS_SCAN_CNT  = 8'h0C;
   localparam logic [7:0] OFS_CHAN_CNT  = 8'h10;
   localparam logic [7:0] OFS_SCAN_INTV = 8'h14;
   localparam logic [7:0] OFS_CHAN_INTV = 8'h18;
   localparam logic [7:0] OFS_SETTLE    = 8'h1C;
   localparam logic [7:0] OFS_LIST_LEN  = 8'h20;
   localparam logic [7:0] OFS_STATUS    = 8'h24;

   localparam int CTRL_INIT_BIT     = 0;
   localparam int CTRL_OPEN_ALL_BIT = 1;
   localparam int SP_ARM_LSB        = 0;
   localparam int SP_SCAN_LSB       = 4;
   localparam int SP_CHAN_LSB       = 8;
   localparam int CNT_INF_BIT       = 16;
   localparam int ST_ARMED_BIT      = 7;
   localparam int ST_PTR_LSB        = 8;
   localparam int ST_CLOSED_BIT     = 16;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [2:0]  RST_ARM_SP   = 3'h0;
   localparam logic [2:0]  RST_SCAN_SP  = 3'h0;
   localparam logic [2:0]  RST_CHAN_SP  = 3'h4;
   localparam logic [13:0] RST_CNT      = 14'h0001;
   localparam logic        RST_ARM_INF  = 1'b0;
   localparam logic        RST_SCAN_INF = 1'b0;
   localparam logic        RST_CHAN_INF = 1'b1;
   localparam logic [26:0] RST_INTV     = 27'h000_0001;
   localparam logic [26:0] RST_SETTLE   = 27'h000_0000;
   localparam logic [7:0]  RST_LIST_LEN = 8'h14;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SP_IMM    = 3'h0,
      SP_TIMER  = 3'h1,
      SP_EXT    = 3'h2,
      SP_BUS    = 3'h3,
      SP_MANUAL = 3'h4,
      SP_LINK   = 3'h5
   } tlss_space_t;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_ARM    = 7'h02,
      ST_SCAN   = 7'h04,
      ST_CHAN   = 7'h08,
      ST_OPEN   = 7'h10,
      ST_CLOSE  = 7'h20,
      ST_SETTLE = 7'h40
   } tlss_state_t;

endpackage

// [hdl/tlss_sequencer.sv]
// Three-layer arm/scan/channel scan sequencer with APB register access
//
// Summary of operation
// - Idle whenever outside all layers; armed indicator off while idle.
// - Step key or initiate command leaves idle, arms, enters arm layer.
// - Immediate arm spacing passes the arm layer without waiting.
// - Event arm spacing waits only for its selected event source; timer arm spacing passes at once.
// - Arm count 1 to 9999 or infinite; return to arm until used up.
// - Arm layer leads to scan layer, scan layer to channel layer.
// - Immediate scan spacing goes on to the channel layer at once.
// - Event scan spacing holds in scan layer until the event arrives.
// - Timer scan spacing: first scan immediate, later scans wait timer.
// - Interval timer spans 1 ms to 99999.999 s in 1 ms steps.
// - Scan count 1 to 9999 or infinite; scans repeat to the count.
// - Immediate channel spacing scans each channel at once.
// - Event channel spacing waits for the event before each channel.
// - Timer channel spacing: first channel immediate, rest wait timer.
// - Channel count 1 to 9999 or infinite, normally the list length.
// - Scan interval runs from one scan start to the next start.
// - Open-all aborts the scan, opens every channel, returns to idle.
// - Open the previous channel before closing the next one.
// - One settling delay for every slot starts after each channel closes.
`timescale 1ns/100ps
module tlss_sequencer
   import tlss_pkg::*;
#(
   parameter int PRE_CYC = MS_CYC
) (
   input  wire logic              CLK_SYS,
   input  wire logic              RST_B,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              STEP_KEY,
   input  wire logic              EXT_TRIG,
   input  wire logic              LINK_TRIG,
   input  wire logic              BUS_TRIG,
   output logic                   IDLE,
   output logic                   ARMED,
   output logic      [LIST_W-1:0] RELAY_IDX,
   output logic                   RELAY_CLOSE,
   output logic                   RELAY_OPEN_ALL
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic [13:0] clamp_cnt(input logic [31:0] v);
      if (v[13:0] == '0 || v[31:14] != '0) begin
         clamp_cnt = (v == '0) ? CNT_MIN : CNT_MAX;
      end else begin
         clamp_cnt = (v[13:0] > CNT_MAX) ? CNT_MAX : v[13:0];
      end
   endfunction

   function automatic logic [26:0] clamp_intv(input logic [31:0] v, input logic zero_ok);
      if (v[31:27] != '0 || v[26:0] > INTV_MAX) begin
         clamp_intv = INTV_MAX;
      end else if (v[26:0] == '0 && !zero_ok) begin
         clamp_intv = INTV_MIN;
      end else begin
         clamp_intv = v[26:0];
      end
   endfunction

   // Last pass of a layer; an infinite flag keeps it from ever ending
   function automatic logic cnt_last(input logic [13:0] c, input logic [13:0] lim,
                                     input logic inf);
      cnt_last = !inf && (14'(c + 14'h0001) >= lim);
   endfunction

   function automatic logic space_hit(input logic [2:0] sp, input logic first,
                                      input logic tmr, input logic [3:0] ev);
      case (sp)
         SP_IMM:    space_hit = 1'b1;
         SP_TIMER:  space_hit = first | tmr;
         SP_EXT:    space_hit = ev[0];
         SP_BUS:    space_hit = ev[1];
         SP_MANUAL: space_hit = ev[2];
         SP_LINK:   space_hit = ev[3];
         default:   space_hit = 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] filt_q;
   logic [2:0] filt_d;
   logic [2:0] rise_q;
   logic [2:0] rise_d;
   logic [3:0] ev;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         filt_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : filt_q[i];
      end
      rise_d = filt_d & ~filt_q;
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         filt_q <= '0;
         rise_q <= '0;
      end else begin
         s1_q   <= {LINK_TRIG, EXT_TRIG, STEP_KEY};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
         rise_q <= rise_d;
      end
   end

   // Event vector: link, manual key, bus trigger, external trigger
   assign ev = {rise_q[2], rise_q[0], BUS_TRIG, rise_q[1]};

   // ---------------------------------------------------------------
   // APB register file
   // ---------------------------------------------------------------
   logic [2:0]        sp_q [3];
   logic [2:0]        sp_d [3];
   logic [13:0]       lim_q [3];
   logic [13:0]       lim_d [3];
   logic              inf_q [3];
   logic              inf_d [3];
   logic [26:0]       intv_q [3];
   logic [26:0]       intv_d [3];
   logic [LIST_W-1:0] len_q;
   logic [LIST_W-1:0] len_d;
   logic [31:0]       rdata_d;
   logic              rdy_d;
   logic              err_d;
   logic              hit;
   logic              wr;
   logic              start_req;
   logic              open_req;
   tlss_state_t       state_q;
   logic [LIST_W-1:0] ptr_q;
   logic              armed_q;
   logic              close_q;

   assign wr = PSEL && PENABLE && PREADY && PWRITE;

   always_comb begin
      sp_d    = sp_q;
      lim_d   = lim_q;
      inf_d   = inf_q;
      intv_d  = intv_q;
      len_d   = len_q;
      hit     = 1'b1;
      rdata_d = '0;
      unique case (PADDR)
         OFS_CTRL:      rdata_d = '0;
         OFS_SPACING:   rdata_d = {21'h0, sp_q[2], 1'b0, sp_q[1], 1'b0, sp_q[0]};
         OFS_ARM_CNT:   rdata_d = {15'h0, inf_q[0], 2'h0, lim_q[0]};
         OFS_SCAN_CNT:  rdata_d = {15'h0, inf_q[1], 2'h0, lim_q[1]};
         OFS_CHAN_CNT:  rdata_d = {15'h0, inf_q[2], 2'h0, lim_q[2]};
         OFS_SCAN_INTV: rdata_d = {5'h0, intv_q[0]};
         OFS_CHAN_INTV: rdata_d = {5'h0, intv_q[1]};
         OFS_SETTLE:    rdata_d = {5'h0, intv_q[2]};
         OFS_LIST_LEN:  rdata_d = {24'h0, len_q};
         OFS_STATUS:    rdata_d = {15'h0, close_q, ptr_q, armed_q, state_q};
         default:       hit = 1'b0;
      endcase
      if (wr) begin
         for (int i = 0; i < 3; i++) begin
            if (PADDR == OFS_ARM_CNT + 8'(4 * i)) begin
               lim_d[i] = clamp_cnt({18'h0, PWDATA[13:0]});
               inf_d[i] = PWDATA[CNT_INF_BIT];
            end
            if (PADDR == OFS_SCAN_INTV + 8'(4 * i)) begin
               intv_d[i] = clamp_intv(PWDATA, i == 2);
            end
         end
         if (PADDR == OFS_SPACING) begin
            sp_d[0] = PWDATA[SP_ARM_LSB +: 3];
            sp_d[1] = PWDATA[SP_SCAN_LSB +: 3];
            sp_d[2] = PWDATA[SP_CHAN_LSB +: 3];
         end
         if (PADDR == OFS_LIST_LEN) begin
            len_d = (PWDATA[LIST_W-1:0] == '0) ? LIST_W'(1) : PWDATA[LIST_W-1:0];
         end
      end
      rdy_d = PSEL && !PENABLE;
      err_d = rdy_d && !hit;
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         sp_q    <= '{RST_ARM_SP, RST_SCAN_SP, RST_CHAN_SP};
         lim_q   <= '{RST_CNT, RST_CNT, RST_CNT};
         inf_q   <= '{RST_ARM_INF, RST_SCAN_INF, RST_CHAN_INF};
         intv_q  <= '{RST_INTV, RST_INTV, RST_SETTLE};
         len_q   <= RST_LIST_LEN;
         PRDATA  <= '0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         sp_q    <= sp_d;
         lim_q   <= lim_d;
         inf_q   <= inf_d;
         intv_q  <= intv_d;
         len_q   <= len_d;
         PRDATA  <= rdy_d ? rdata_d : '0;
         PREADY  <= rdy_d;
         PSLVERR <= err_d;
      end
   end

   assign open_req  = wr && PADDR == OFS_CTRL && PWDATA[CTRL_OPEN_ALL_BIT];
   assign start_req = rise_q[0] || (wr && PADDR == OFS_CTRL && PWDATA[CTRL_INIT_BIT]);

   // ---------------------------------------------------------------
   // Interval timers: scan, channel, settling
   // ---------------------------------------------------------------
   logic [2:0] ld;
   logic [2:0] tmr_exp;

   for (genvar g = 0; g < 3; g++) begin : g_tmr
      tlss_ms_timer #(
         .W       (INTV_W),
         .PRE_CYC (PRE_CYC)
      ) u_tmr (
         .clk      (CLK_SYS),
         .rst_b    (RST_B),
         .load     (ld[g]),
         .load_val (intv_q[g]),
         .expired  (tmr_exp[g])
      );
   end

   // ---------------------------------------------------------------
   // Layer state machine
   // ---------------------------------------------------------------
   tlss_state_t       state_d;
   logic [13:0]       cnt_q [3];
   logic [13:0]       cnt_d [3];
   logic              sfirst_q;
   logic              sfirst_d;
   logic              cfirst_q;
   logic              cfirst_d;
   logic [LIST_W-1:0] ptr_d;
   logic [LIST_W-1:0] idx_q;
   logic [LIST_W-1:0] idx_d;
   logic              armed_d;
   logic              close_d;
   logic              oall_q;
   logic              oall_d;
   logic [2:0]        last;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         last[i] = cnt_last(cnt_q[i], lim_q[i], inf_q[i]);
      end
      state_d  = state_q;
      cnt_d    = cnt_q;
      sfirst_d = sfirst_q;
      cfirst_d = cfirst_q;
      ptr_d    = ptr_q;
      idx_d    = idx_q;
      close_d  = close_q;
      oall_d   = 1'b0;
      ld       = '0;
      if (open_req) begin
         state_d = ST_IDLE;
         close_d = 1'b0;
         oall_d  = 1'b1;
      end else begin
         unique case (state_q)
            ST_IDLE: if (start_req) begin
               state_d = ST_ARM;
               cnt_d   = '{14'h0, 14'h0, 14'h0};
               ptr_d   = '0;
            end
            ST_ARM: if (space_hit(sp_q[0], 1'b1, 1'b0, ev)) begin
               state_d  = ST_SCAN;
               cnt_d[1] = '0;
               sfirst_d = 1'b1;
            end
            ST_SCAN: if (space_hit(sp_q[1], sfirst_q, tmr_exp[0], ev)) begin
               state_d  = ST_CHAN;
               ld[0]    = 1'b1;
               sfirst_d = 1'b0;
               cnt_d[2] = '0;
               cfirst_d = 1'b1;
            end
            ST_CHAN: if (space_hit(sp_q[2], cfirst_q, tmr_exp[1], ev)) begin
               state_d  = ST_OPEN;
               ld[1]    = 1'b1;
               cfirst_d = 1'b0;
               close_d  = 1'b0;
            end
            ST_OPEN: begin
               state_d = ST_CLOSE;
               idx_d   = ptr_q;
               close_d = 1'b1;
            end
            ST_CLOSE: begin
               state_d = ST_SETTLE;
               ld[2]   = 1'b1;
            end
            ST_SETTLE: if (tmr_exp[2]) begin
               ptr_d    = (14'(ptr_q) + 14'h1 >= 14'(len_q)) ? '0 : ptr_q + LIST_W'(1);
               cnt_d[2] = cnt_q[2] + 14'h0001;
               state_d  = ST_CHAN;
               if (last[2]) begin
                  cnt_d[1] = cnt_q[1] + 14'h0001;
                  state_d  = ST_SCAN;
                  if (last[1]) begin
                     cnt_d[0] = cnt_q[0] + 14'h0001;
                     state_d  = last[0] ? ST_IDLE : ST_ARM;
                  end
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
      armed_d = (state_d != ST_IDLE);
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state_q  <= ST_IDLE;
         cnt_q    <= '{14'h0, 14'h0, 14'h0};
         sfirst_q <= 1'b1;
         cfirst_q <= 1'b1;
         ptr_q    <= '0;
         idx_q    <= '0;
         armed_q  <= 1'b0;
         close_q  <= 1'b0;
         oall_q   <= 1'b0;
         IDLE     <= 1'b1;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         sfirst_q <= sfirst_d;
         cfirst_q <= cfirst_d;
         ptr_q    <= ptr_d;
         idx_q    <= idx_d;
         armed_q  <= armed_d;
         close_q  <= close_d;
         oall_q   <= oall_d;
         IDLE     <= (state_d == ST_IDLE);
      end
   end

   assign ARMED          = armed_q;
   assign RELAY_IDX      = idx_q;
   assign RELAY_CLOSE    = close_q;
   assign RELAY_OPEN_ALL = oall_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   a_idle_not_armed: assert property (
      IDLE == !ARMED && IDLE == (state_q == ST_IDLE))
      else $error("Idle and armed indicators disagree");
   a_start_arms: assert property (
      state_q == ST_IDLE && start_req && !open_req |=> state_q == ST_ARM && ARMED)
      else $error("Start request did not arm");
   a_arm_immediate: assert property (
      state_q == ST_ARM && sp_q[0] == SP_IMM && !open_req |=> state_q == ST_SCAN)
      else $error("Immediate arm did not pass through");
   a_arm_waits_ext: assert property (
      state_q == ST_ARM && sp_q[0] == SP_EXT && !ev[0] && !open_req |=> state_q == ST_ARM)
      else $error("Arm layer left without its event");
   a_arm_repeat: assert property (
      state_q == ST_SETTLE && tmr_exp[2] && last == 3'b110 && !open_req
      |=> state_q == ST_ARM)
      else $error("Arm count not honoured");
   a_scan_to_chan: assert property (
      state_q == ST_SCAN && sp_q[1] == SP_IMM && !open_req |=> state_q == ST_CHAN)
      else $error("Immediate scan did not reach channel layer");
   a_scan_holds_bus: assert property (
      state_q == ST_SCAN && sp_q[1] == SP_BUS && !BUS_TRIG && !open_req
      |=> state_q == ST_SCAN)
      else $error("Scan layer left without bus trigger");
   a_scan_timer_wait: assert property (
      state_q == ST_SCAN && sp_q[1] == SP_TIMER && !sfirst_q && !tmr_exp[0] && !open_req
      |=> state_q == ST_SCAN)
      else $error("Timed scan started before interval");
   a_chan_immediate: assert property (
      state_q == ST_CHAN && sp_q[2] == SP_IMM && !open_req ##1 !open_req
      |-> state_q == ST_OPEN ##1 RELAY_CLOSE)
      else $error("Immediate channel not closed");
   a_chan_timer_wait: assert property (
      state_q == ST_CHAN && sp_q[2] == SP_TIMER && !cfirst_q && !tmr_exp[1] && !open_req
      |=> state_q == ST_CHAN)
      else $error("Timed channel scanned before interval");
   a_open_all: assert property (
      open_req |=> IDLE && !RELAY_CLOSE && RELAY_OPEN_ALL && !ARMED)
      else $error("Open-all did not abort");
   a_break_make: assert property (
      RELAY_CLOSE && $past(RELAY_CLOSE) |-> RELAY_IDX == $past(RELAY_IDX))
      else $error("Channel switched without opening first");
   a_settle_start: assert property (
      state_q == ST_CLOSE && !open_req |=> state_q == ST_SETTLE && RELAY_CLOSE)
      else $error("Settling did not follow closure");

   c_start:     cover property (state_q == ST_IDLE ##1 state_q == ST_ARM);
   c_full_run:  cover property (state_q == ST_SETTLE ##1 state_q == ST_IDLE);
   c_scan_wait: cover property (state_q == ST_SCAN && sp_q[1] == SP_TIMER && !sfirst_q);
   c_open_all:  cover property (open_req && state_q == ST_SETTLE);

endmodule

// [verification/testbench.sv]
// Self-checking bench: register access, all spacing codes, wrap and open-all
`timescale 1ns/100ps
module testbench
   import tlss_pkg::*;
;
   logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, en = 0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [7:0]  ridx;
   logic [2:0]  src = '0;
   logic        pready, pslverr, step, ext, link, bus, idle, armed, rclose, oall, prev_close = 0;
   logic [32:0] rdq[$];
   logic [7:0]  rlq[$];
   int          num_errors = 0, n_checks = 0, cyc = 0, seed = 28875, n;
   int          ctq[$];

   tlss_sequencer #(.PRE_CYC(4)) i_dut (.CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STEP_KEY(step),
      .EXT_TRIG(ext), .LINK_TRIG(link), .BUS_TRIG(bus), .IDLE(idle), .ARMED(armed),
      .RELAY_IDX(ridx), .RELAY_CLOSE(rclose), .RELAY_OPEN_ALL(oall));
   tlss_trig_src i_src (.clk(clk), .en(en), .src(src), .step_key(step),
      .ext_trig(ext), .link_trig(link), .bus_trig(bus));

   initial begin
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task print_verdict;
      if (num_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1;
      penable <= 0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 0;
      penable <= 0;
   endtask

   // Result watcher: read answers and channel closures against noted values
   always @(posedge clk) begin
      cyc++;
      prev_close <= rclose;
      if (psel && penable && pready && !pwrite)
         check({pslverr, prdata}, rdq.pop_front());
      if (rclose && !prev_close) begin
         ctq.push_back(cyc);
         check({25'h0, ridx}, {25'h0, rlq.pop_front()});
      end
      if (cyc == 40000) begin
         num_errors++;
         print_verdict;
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      check({31'h0, idle, armed}, 33'h0_0000_0002);
      rdq.push_back(33'h0_0000_0001);
      apb(0, OFS_STATUS, 32'h0000_0000);
      rdq.push_back(33'h0_0000_0400);
      apb(0, OFS_SPACING, 32'h0000_0000);
      rdq.push_back(33'h1_0000_0000);
      apb(0, 8'h28, 32'h0000_0000);
      apb(1, OFS_LIST_LEN, 32'h0000_0002);
      // Every spacing code on arm and channel layers, random channel count
      for (int c = 0; c < 6; c++) begin
         n = 1 + ($unsigned($random(seed)) % 4);
         for (int i = 0; i < n; i++)
            rlq.push_back(8'(i % 2));
         apb(1, OFS_CHAN_CNT, 32'(n));
         apb(1, OFS_SPACING, 32'(c) | (32'(c) << 8));
         apb(1, OFS_CTRL, 32'h0000_0001);
         src <= 3'(c);
         en  <= 1;
         repeat (2) @(posedge clk);
         check({31'h0, idle, armed}, 33'h0_0000_0001);
         for (int k = 0; k < 3000 && idle !== 1'b1; k++)
            @(posedge clk);
         en <= 0;
         check(33'(rlq.size()), 33'h0_0000_0000);
         check({31'h0, idle, armed}, 33'h0_0000_0002);
      end
      // Two arms of two timed scans, one channel each: start-to-start spacing
      apb(1, OFS_ARM_CNT, 32'h0000_0002);
      apb(1, OFS_SCAN_CNT, 32'h0000_0002);
      apb(1, OFS_CHAN_CNT, 32'h0000_0001);
      apb(1, OFS_SCAN_INTV, 32'h0000_0002);
      apb(1, OFS_SPACING, 32'h0000_0010);
      for (int i = 0; i < 4; i++)
         rlq.push_back(8'(i % 2));
      ctq.delete();
      apb(1, OFS_CTRL, 32'h0000_0001);
      repeat (2) @(posedge clk);
      for (int k = 0; k < 3000 && idle !== 1'b1; k++)
         @(posedge clk);
      check(33'(rlq.size()), 33'h0_0000_0000);
      check(33'(ctq.size()), 33'h0_0000_0004);
      check({32'h0, (ctq[1] - ctq[0]) inside {[8:11]}}, 33'h0_0000_0001);
      check({32'h0, (ctq[2] - ctq[1]) < 8}, 33'h0_0000_0001);
      check({32'h0, (ctq[3] - ctq[2]) inside {[8:11]}}, 33'h0_0000_0001);
      // Abort a waiting run while the last channel is still closed
      apb(1, OFS_SPACING, 32'h0000_0400);
      apb(1, OFS_CTRL, 32'h0000_0001);
      apb(1, OFS_CTRL, 32'h0000_0002);
      @(posedge clk);
      check({32'h0, oall}, 33'h0_0000_0001);
      repeat (2) @(posedge clk);
      check({29'h0, idle, armed, rclose, oall}, 33'h0_0000_0008);
      print_verdict;
   end
endmodule

// [verification/tlss_trig_src.sv]
// Far-side model: trigger sources that pace the sequencer's layers
`timescale 1ns/100ps
module tlss_trig_src
   import tlss_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       en,
   input  wire logic [2:0] src,
   output logic            step_key,
   output logic            ext_trig,
   output logic            link_trig,
   output logic            bus_trig
);
   logic [4:0] cnt_q = 5'h00;
   logic       hi;

   always_ff @(posedge clk) begin
      cnt_q <= en ? cnt_q + 5'h01 : 5'h00;
   end

   // Wide pin pulses outlast the input filter
   assign hi        = en && (cnt_q[4:3] == 2'b11);
   assign step_key  = hi && (src == SP_MANUAL);
   assign ext_trig  = hi && (src == SP_EXT);
   assign link_trig = hi && (src == SP_LINK);
   // Bus trigger is a single-cycle strobe
   assign bus_trig  = en && (cnt_q == 5'h1F) && (src == SP_BUS);
endmodule
